// *** ptc_regs.svh ***
// Register map, field positions and reset values of the periodic tick counter
// Functional notes
// - Every match pulses the converter trigger
// - Debug mode halts counting, value held
// - Stop2 wake keeps all register contents
// - Enabled counter keeps running in wait
// - Counter runs in stop2/stop3, irq wakes
// - Stop2 allows only the low-power oscillator
// - Match flag bit 7, write-one clears
// - Source select bits 6-5, reset zero
// - Changed source clears prescaler and count
// - Interrupt enable bit 4 gates request
// - Divider bits 3-0; change clears counters
// - Binary/decimal divider table, source lsb 0
// - Larger divider table, source lsb 1
// - Bus clock gate set by reset
// - Count to limit, wrap, set flag
// - Limit write clears; count read-only
// - Limit zero flags every prescaler edge
`ifndef PTC_REGS_SVH
`define PTC_REGS_SVH
`define PTC_CTRL_OFS   4'h0
`define PTC_COUNT_OFS  4'h4
`define PTC_LIMIT_OFS  4'h8
`define PTC_GATE_OFS   4'hC
`define PTC_FLAG_BIT   7
`define PTC_SRC_LSB    5
`define PTC_IEN_BIT    4
`define PTC_DIV_LSB    0
`define PTC_CTRL_RST   8'h00
`define PTC_COUNT_RST  8'h00
`define PTC_LIMIT_RST  8'h00
`define PTC_GATE_RST   1'b1
`define PTC_PRE_W      18
`endif

// *** ptc_pkg.sv ***
// Types shared by the periodic tick counter
`default_nettype none
`include "ptc_regs.svh"
package ptc_pkg;
  typedef struct packed {
    logic [2:0]            lpo_sync;
    logic [2:0]            ext_sync;
    logic [2:0]            int_sync;
    logic [1:0]            src_sel;
    logic [3:0]            div_sel;
    logic                  irq_en;
    logic                  flag;
    logic [7:0]            count;
    logic [7:0]            limit;
    logic [`PTC_PRE_W-1:0] pre;
    logic                  gate;
    logic                  wreq;
    logic [31:0]           rdata;
    logic                  irq;
    logic                  trig;
  } ptc_state_type;
endpackage
`default_nettype wire

// *** ptc_top.sv ***
// Periodic tick counter with Avalon-MM register slave
`timescale 1ns/10ps
`default_nettype none
`include "ptc_regs.svh"
module ptc_top
  import ptc_pkg::*;
#(
  parameter int PRE_W = `PTC_PRE_W
) (
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output var  logic [31:0] avs_readdata,
  output var  logic        avs_waitrequest,
  input  wire logic        low_power_osc,
  input  wire logic        external_ref_clock,
  input  wire logic        internal_ref_clock,
  input  wire logic        stop2_mode,
  input  wire logic        debug_mode,
  output var  logic        match_irq,
  output var  logic        converter_trigger
);

  // The prescaler state lives in the shared struct, so its width is fixed
  if (PRE_W != `PTC_PRE_W) begin : g_bad_width
    $error("PRE_W must equal the shared prescaler width");
  end

  // Divide ratio per source lsb and divider code; zero means off
  function automatic logic [PRE_W-1:0] div_ratio(
    input logic       hi_range,
    input logic [3:0] code
  );
    logic [PRE_W-1:0] r;
    r = '0;
    if (!hi_range) begin
      unique case (code)
        4'h0: r = 18'h00000;
        4'h1: r = 18'h00008;
        4'h2: r = 18'h00020;
        4'h3: r = 18'h00040;
        4'h4: r = 18'h00080;
        4'h5: r = 18'h00100;
        4'h6: r = 18'h00200;
        4'h7: r = 18'h00400;
        4'h8: r = 18'h00001;
        4'h9: r = 18'h00002;
        4'hA: r = 18'h00004;
        4'hB: r = 18'h0000A;
        4'hC: r = 18'h00010;
        4'hD: r = 18'h00064;
        4'hE: r = 18'h001F4;
        4'hF: r = 18'h003E8;
      endcase
    end else begin
      unique case (code)
        4'h0: r = 18'h00000;
        4'h1: r = 18'h00400;
        4'h2: r = 18'h00800;
        4'h3: r = 18'h01000;
        4'h4: r = 18'h02000;
        4'h5: r = 18'h04000;
        4'h6: r = 18'h08000;
        4'h7: r = 18'h10000;
        4'h8: r = 18'h003E8;
        4'h9: r = 18'h007D0;
        4'hA: r = 18'h01388;
        4'hB: r = 18'h02710;
        4'hC: r = 18'h04E20;
        4'hD: r = 18'h0C350;
        4'hE: r = 18'h186A0;
        4'hF: r = 18'h30D40;
      endcase
    end
    return r;
  endfunction

  // Rising edge seen between the second and third synchroniser stage
  function automatic logic rise_seen(input logic [2:0] sync);
    return sync[1] && !sync[2];
  endfunction

  logic [1:0]       rst_sync_ff;
  logic             rst_n;
  ptc_state_type    s_ff;
  ptc_state_type    nxt_s;
  logic             wr_acc;
  logic             req_new;
  logic             src_edge;
  logic             src_usable;
  logic             run;
  logic             tick;
  logic             match;
  logic             flag_set;
  logic             ctrl_wr;
  logic             limit_wr;
  logic             gate_wr;
  logic [7:0]       wbyte;
  logic [PRE_W-1:0] ratio;
  logic [7:0]       ctrl_val;

  // Reset is released synchronously, asserted at once
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  assign ctrl_val = {s_ff.flag, s_ff.src_sel, s_ff.irq_en, s_ff.div_sel};
  assign wbyte    = avs_writedata[7:0];
  assign wr_acc   = avs_write && !s_ff.wreq && avs_byteenable[0];
  assign req_new  = (avs_read || avs_write) && s_ff.wreq;
  // Without the bus clock only the gate itself stays writable
  assign ctrl_wr  = wr_acc && s_ff.gate && (avs_address == `PTC_CTRL_OFS);
  assign limit_wr = wr_acc && s_ff.gate && (avs_address == `PTC_LIMIT_OFS);
  assign gate_wr  = wr_acc && (avs_address == `PTC_GATE_OFS);
  assign ratio    = div_ratio(s_ff.src_sel[0], s_ff.div_sel);

  always_comb begin
    nxt_s = s_ff;
    // Third stage only feeds the edge detector
    nxt_s.lpo_sync = {s_ff.lpo_sync[1:0], low_power_osc};
    nxt_s.ext_sync = {s_ff.ext_sync[1:0], external_ref_clock};
    nxt_s.int_sync = {s_ff.int_sync[1:0], internal_ref_clock};
    unique case (s_ff.src_sel)
      2'b00:   src_edge = rise_seen(s_ff.lpo_sync);
      2'b01:   src_edge = rise_seen(s_ff.ext_sync);
      default: src_edge = rise_seen(s_ff.int_sync);
    endcase
    src_usable = !(stop2_mode && (s_ff.src_sel != 2'b00));
    // Wait does not halt counting; stop2 halts all but the oscillator source; debug halts all
    run = (s_ff.div_sel != 4'h0) && src_usable && !debug_mode;
    tick = 1'b0;
    if (run && src_edge) begin
      if (s_ff.pre >= ratio - 18'h00001) begin
        nxt_s.pre = '0;
        tick = 1'b1;
      end else begin
        nxt_s.pre = s_ff.pre + 18'h00001;
      end
    end
    match = tick && (s_ff.count == s_ff.limit);
    flag_set = match;
    if (tick) begin
      if (match) begin
        nxt_s.count = 8'h00;
      end else begin
        nxt_s.count = s_ff.count + 8'h01;
      end
    end
    nxt_s.trig = match;
    if (ctrl_wr) begin
      nxt_s.src_sel = wbyte[`PTC_SRC_LSB+:2];
      nxt_s.irq_en  = wbyte[`PTC_IEN_BIT];
      nxt_s.div_sel = wbyte[`PTC_DIV_LSB+:4];
      if ((wbyte[`PTC_SRC_LSB+:2] != s_ff.src_sel) ||
          (wbyte[`PTC_DIV_LSB+:4] != s_ff.div_sel)) begin
        nxt_s.pre   = '0;
        nxt_s.count = 8'h00;
      end
    end
    // A match in the clearing cycle keeps the flag
    nxt_s.flag = (s_ff.flag && !(ctrl_wr && wbyte[`PTC_FLAG_BIT])) ||
                 flag_set;
    if (limit_wr) begin
      nxt_s.limit = wbyte;
      nxt_s.pre   = '0;
      nxt_s.count = 8'h00;
    end
    if (gate_wr) begin
      nxt_s.gate = wbyte[0];
    end
    nxt_s.irq = nxt_s.flag && nxt_s.irq_en;
    // One wait state: answer loads on the cycle after the request
    nxt_s.wreq = 1'b1;
    if (req_new) begin
      nxt_s.wreq  = 1'b0;
      nxt_s.rdata = 32'h00000000;
      if (avs_read) begin
        unique case (avs_address)
          `PTC_CTRL_OFS:  nxt_s.rdata = {24'h000000, s_ff.gate ? ctrl_val : 8'h00};
          `PTC_COUNT_OFS: nxt_s.rdata = {24'h000000, s_ff.gate ? s_ff.count : 8'h00};
          `PTC_LIMIT_OFS: nxt_s.rdata = {24'h000000, s_ff.gate ? s_ff.limit : 8'h00};
          `PTC_GATE_OFS:  nxt_s.rdata = {31'h00000000, s_ff.gate};
          default:        nxt_s.rdata = 32'h00000000;
        endcase
      end
    end
  end

  // Stop2 wake is not a reset, so state simply persists
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_ff         <= '0;
      s_ff.src_sel <= 2'(`PTC_CTRL_RST >> `PTC_SRC_LSB);
      s_ff.count   <= `PTC_COUNT_RST;
      s_ff.limit   <= `PTC_LIMIT_RST;
      s_ff.gate    <= `PTC_GATE_RST;
      s_ff.wreq    <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign avs_readdata      = s_ff.rdata;
  assign avs_waitrequest   = s_ff.wreq;
  assign match_irq         = s_ff.irq;
  assign converter_trigger = s_ff.trig;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  match_trigger_a: assert property (
    match && !ctrl_wr && !limit_wr |=> converter_trigger && s_ff.count == 8'h00
  ) else $error("match did not pulse trigger and wrap count");

  trigger_pulse_a: assert property (
    converter_trigger |-> $past(s_ff.count) == $past(s_ff.limit)
  ) else $error("trigger without a preceding limit match");

  flag_set_a: assert property (
    match |=> s_ff.flag
  ) else $error("match did not set the flag");

  debug_hold_a: assert property (
    debug_mode && !ctrl_wr && !limit_wr |=> $stable(s_ff.count) && $stable(s_ff.pre)
  ) else $error("count moved during debug");

  flag_clear_a: assert property (
    ctrl_wr && wbyte[`PTC_FLAG_BIT] && !match |=> !s_ff.flag && !match_irq
  ) else $error("write one did not clear flag and request");

  flag_keep_a: assert property (
    ctrl_wr && !wbyte[7] && s_ff.flag |=> s_ff.flag
  ) else $error("write zero disturbed the flag");

  irq_follow_a: assert property (
    match_irq == (s_ff.flag && s_ff.irq_en)
  ) else $error("interrupt request does not follow flag and enable");

  limit_clear_a: assert property (
    limit_wr |=> s_ff.count == 8'h00 && s_ff.pre == '0 && s_ff.limit == $past(wbyte)
  ) else $error("limit write did not clear counters");

  sel_change_a: assert property (
    ctrl_wr && (wbyte[6:5] != s_ff.src_sel) |=> s_ff.count == 8'h00 && s_ff.pre == '0
  ) else $error("source change did not clear counters");

  div_off_a: assert property (
    s_ff.div_sel == 4'h0 && !ctrl_wr && !limit_wr |=> $stable(s_ff.count)
  ) else $error("count moved with divider off");

  stop2_src_a: assert property (
    stop2_mode && s_ff.src_sel != 2'b00 |-> !tick
  ) else $error("non oscillator source ticked in stop2");

  bus_answer_a: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest
  ) else $error("bus answer not given after one wait state");

  // Counting and selection checks
  div_change_a: assert property (
    ctrl_wr && (wbyte[`PTC_DIV_LSB+:4] != s_ff.div_sel) |=>
      s_ff.count == 8'h00 && s_ff.pre == '0
  ) else $error("divider change did not clear counters");

  same_sel_a: assert property (
    ctrl_wr && (wbyte[`PTC_SRC_LSB+:2] == s_ff.src_sel) &&
      (wbyte[`PTC_DIV_LSB+:4] == s_ff.div_sel) && !tick |=> $stable(s_ff.count)
  ) else $error("rewriting the same selection moved the count");

  ctrl_fields_a: assert property (
    ctrl_wr |=> s_ff.src_sel == $past(wbyte[`PTC_SRC_LSB+:2]) &&
      s_ff.div_sel == $past(wbyte[`PTC_DIV_LSB+:4]) &&
      s_ff.irq_en == $past(wbyte[`PTC_IEN_BIT])
  ) else $error("control write did not load its fields");

  count_step_a: assert property (
    tick && !match && !ctrl_wr && !limit_wr |=> s_ff.count == $past(s_ff.count) + 8'h01
  ) else $error("tick did not advance the count");

  tick_wrap_a: assert property (
    tick |=> s_ff.pre == '0
  ) else $error("prescaler did not restart after its output");

  pre_bound_a: assert property (
    s_ff.div_sel != 4'h0 |-> s_ff.pre < ratio
  ) else $error("prescaler ran past its divide ratio");

  limit_zero_a: assert property (
    tick && (s_ff.limit == 8'h00) |-> match
  ) else $error("zero limit did not match on a tick");

  count_ro_a: assert property (
    wr_acc && (avs_address == `PTC_COUNT_OFS) && !tick |=> $stable(s_ff.count)
  ) else $error("write to the count register moved it");

  debug_tick_a: assert property (
    debug_mode |-> !tick
  ) else $error("prescaler produced a tick during debug");

  stop2_run_a: assert property (
    stop2_mode && (s_ff.src_sel == 2'b00) && (s_ff.div_sel == 4'h8) && !debug_mode &&
      src_edge |-> tick
  ) else $error("oscillator source did not count in stop2");

  trig_only_a: assert property (
    !match |=> !converter_trigger
  ) else $error("trigger pulse without a match");

  irq_off_a: assert property (
    !s_ff.irq_en |-> !match_irq
  ) else $error("interrupt request with the enable clear");

  gate_block_a: assert property (
    wr_acc && !s_ff.gate && (avs_address == `PTC_CTRL_OFS) |=>
      $stable(s_ff.src_sel) && $stable(s_ff.div_sel) && $stable(s_ff.irq_en)
  ) else $error("control changed while the bus clock was gated");

  gate_write_a: assert property (
    gate_wr |=> s_ff.gate == $past(wbyte[0])
  ) else $error("gate register did not take the written bit");

  // Bus checks; they pin the single wait state and the byte lane
  read_limit_a: assert property (
    avs_read && avs_waitrequest && s_ff.gate && (avs_address == `PTC_LIMIT_OFS) |=>
      avs_readdata == {24'h000000, $past(s_ff.limit)}
  ) else $error("limit read returned the wrong value");

  idle_wait_a: assert property (
    !avs_read && !avs_write |=> avs_waitrequest
  ) else $error("waitrequest dropped without a request");

  lane_off_a: assert property (
    avs_write && !avs_waitrequest && !avs_byteenable[0] |=> $stable(s_ff.limit)
  ) else $error("write with the low byte disabled took effect");

endmodule
`default_nettype wire

// *** periodic_tick_counter_bench.sv ***
// Self-checking random bench for the periodic tick counter
`timescale 1ns/10ps
`default_nettype none
module periodic_tick_counter_bench;
  logic        clk_sys = 0;
  logic        arst_n = 0;
  logic [3:0]  adr = 0;
  logic        rd = 0;
  logic        wr = 0;
  logic [31:0] wdat = 0;
  logic [31:0] rdat;
  logic        wreq;
  logic [2:0]  pins = 0;
  logic        stop2 = 0;
  logic        dbg = 0;
  logic        irq;
  logic        trig;
  logic [31:0] seed = 6;
  logic [31:0] q;
  logic [1:0]  s;
  logic [3:0]  c;
  logic [3:0]  cs [5] = '{4'h1, 4'h8, 4'h9, 4'hA, 4'hB};
  int          error_cnt = 0;
  int          checks_done = 0;
  int          trig_n = 0;
  int          cyc = 0;
  int          r;
  int          n;

  ptc_top #(.PRE_W(18)) dut (.clk_sys(clk_sys), .arst_n(arst_n), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wdat), .avs_byteenable(4'hF),
    .avs_readdata(rdat), .avs_waitrequest(wreq), .low_power_osc(pins[0]),
    .external_ref_clock(pins[1]), .internal_ref_clock(pins[2]), .stop2_mode(stop2),
    .debug_mode(dbg), .match_irq(irq), .converter_trigger(trig));

  initial forever #25 clk_sys = ~clk_sys;

  // Ceiling well above the longest random mix of 1000-edge ticks
  always @(posedge clk_sys) begin
    if (trig === 1'b1) trig_n <= trig_n + 1;
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      error_cnt = error_cnt + 1;
      wrap_up();
    end
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic int ratio(logic lsb, logic [3:0] code);
    int t0 [16] = '{0, 8, 32, 64, 128, 256, 512, 1024, 1, 2, 4, 10, 16, 100, 500, 1000};
    int t1 [16] = '{0, 1024, 2048, 4096, 8192, 16384, 32768, 65536, 1000, 2000, 5000,
                    10000, 20000, 50000, 100000, 200000};
    return lsb ? t1[code] : t0[code];
  endfunction

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Request held until the edge that samples waitrequest low
  task automatic bus(logic w, logic [3:0] a, logic [31:0] d);
    @(posedge clk_sys);
    rd <= !w;
    wr <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_sys); while (wreq !== 1'b0);
    q = rdat;
    rd <= 0;
    wr <= 0;
  endtask

  task automatic rdc(logic [3:0] a, logic [31:0] e, string name);
    bus(0, a, 32'h0);
    check(name, q, e);
  endtask

  // Edges 5 cycles apart, then room for the synchroniser lag
  task automatic pulse(int cnt, int p);
    repeat (cnt) begin
      @(posedge clk_sys) pins[p] <= 1;
      repeat (2) @(posedge clk_sys);
      pins[p] <= 0;
      repeat (2) @(posedge clk_sys);
    end
    repeat (6) @(posedge clk_sys);
  endtask

  task automatic run(logic [1:0] sel, logic [3:0] code, logic [7:0] lim, int e, logic ien);
    int t;
    int l;
    l = lim;
    t = e / ratio(sel[0], code);
    bus(1, 4'h0, {24'h0, 1'b1, sel, ien, code});
    bus(1, 4'h8, {24'h0, lim});
    trig_n = 0;
    pulse(e, sel[1] ? 2 : int'(sel[0]));
    rdc(4'h4, t % (l + 1), "count");
    check("triggers", trig_n, t / (l + 1));
    rdc(4'h0, {24'h0, t > l, sel, ien, code}, "control");
    check("irq", irq, ien && t > l);
  endtask

  initial begin
    repeat (12) @(posedge clk_sys);
    arst_n <= 1;
    repeat (4) @(posedge clk_sys);
    rdc(4'hC, 32'h1, "gate");
    rdc(4'h0, 32'h0, "control");
    rdc(4'h8, 32'h0, "limit");
    rdc(4'h2, 32'h0, "unmapped");
    bus(1, 4'h4, 32'hFF);
    rdc(4'h4, 32'h0, "count ro");
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      s = 2'(rnd());
      c = s[0] ? 4'h8 : cs[rnd() % 5];
      r = ratio(s[0], c);
      n = r * int'(rnd() % (s[0] ? 2 : 12)) + int'(rnd() % r);
      run(s, c, (i == 0) ? 8'h00 : 8'(rnd() % 4), n, 1'(rnd()));
      $display("test random %0d done", i);
    end
    run(2'b00, 4'h8, 8'hFF, 5, 0);
    bus(1, 4'h0, 32'h08);
    rdc(4'h4, 32'h5, "count");
    bus(1, 4'h0, 32'h48);
    rdc(4'h4, 32'h0, "count");
    pulse(3, 2);
    bus(1, 4'h0, 32'h49);
    rdc(4'h4, 32'h0, "count");
    pulse(2, 2);
    bus(1, 4'h8, 32'h40);
    rdc(4'h4, 32'h0, "count");
    bus(1, 4'h0, 32'h48);
    pulse(2, 2);
    dbg <= 1;
    pulse(4, 2);
    rdc(4'h4, 32'h2, "count");
    dbg <= 0;
    pulse(3, 2);
    rdc(4'h4, 32'h5, "count");
    stop2 <= 1;
    pulse(3, 2);
    rdc(4'h4, 32'h5, "count");
    bus(1, 4'h0, 32'h08);
    pulse(3, 0);
    rdc(4'h4, 32'h3, "count");
    stop2 <= 0;
    bus(1, 4'h0, 32'h00);
    pulse(4, 0);
    rdc(4'h4, 32'h0, "count");
    $display("test clearing and modes done");
    run(2'b00, 4'h8, 8'h00, 2, 1);
    bus(1, 4'h0, 32'h18);
    rdc(4'h0, 32'h98, "control");
    check("irq", irq, 1);
    bus(1, 4'h0, 32'h98);
    rdc(4'h0, 32'h18, "control");
    check("irq", irq, 0);
    bus(1, 4'hC, 32'h0);
    rdc(4'h0, 32'h0, "gated");
    bus(1, 4'h0, 32'h7F);
    bus(1, 4'hC, 32'h1);
    rdc(4'h0, 32'h18, "control");
    $display("test flag and gate done");
    wrap_up();
  end
endmodule
`default_nettype wire
